// ===== ccd_top.sv
// two channel clock dividers with register port and output pair routing
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps

module ccd_top
  import ccd_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_srst,
  input  wire logic        i_ce,
  input  wire logic [9:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic        i_osc_clk,
  input  wire logic        i_ext_clk,
  input  wire logic        i_chip_sync,
  output logic [7:0]       o_rdata,
  output logic             o_pair0_output_a,
  output logic             o_pair0_output_b,
  output logic             o_pair1_output_a,
  output logic             o_pair1_output_b,
  output logic [1:0]       o_duty_correct_en
);

  // ************************************************************
  // configuration registers
  // ************************************************************
  logic [7:0] div0_counts_reg;
  logic [7:0] div0_ctrl_reg;
  logic [7:0] div0_route_reg;
  logic [7:0] div1_counts_reg;
  logic [7:0] div1_ctrl_reg;
  logic [7:0] div1_route_reg;
  logic [1:0] src_sel_reg;
  logic [7:0] rdata_reg;
  logic [7:0] status_next;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      div0_counts_reg <= CCD_DIV0_COUNTS_RST;
      div0_ctrl_reg   <= CCD_DIV0_CTRL_RST;
      div0_route_reg  <= CCD_DIV0_ROUTE_RST;
      div1_counts_reg <= CCD_DIV1_COUNTS_RST;
      div1_ctrl_reg   <= CCD_DIV1_CTRL_RST;
      div1_route_reg  <= CCD_DIV1_ROUTE_RST;
      src_sel_reg     <= CCD_SRC_SEL_RST;
    end else if (i_ce && i_wr) begin
      case (i_addr)
        CCD_DIV0_COUNTS: div0_counts_reg <= i_wdata;
        CCD_DIV0_CTRL:   div0_ctrl_reg   <= i_wdata;
        CCD_DIV0_ROUTE:  div0_route_reg  <= {6'h00, i_wdata[1:0]};
        CCD_DIV1_COUNTS: div1_counts_reg <= i_wdata;
        CCD_DIV1_CTRL:   div1_ctrl_reg   <= i_wdata;
        CCD_DIV1_ROUTE:  div1_route_reg  <= {6'h00, i_wdata[1:0]};
        CCD_SRC_SEL:     src_sel_reg     <= i_wdata[1:0];
        default: begin
        end
      endcase
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  logic       osc_lvl;
  logic       ext_lvl;
  logic       osc_rise;
  logic       ext_rise;
  logic       sync_lvl;
  logic       div0_out;
  logic       div1_out;
  logic       div0_run;
  logic       div1_run;

  assign status_next = {2'h0, sync_lvl, ext_lvl, div1_out, div0_out, div1_run, div0_run};

  // data lasts only the cycle after the strobe while i_ce is high, and holds while i_ce is low; unmapped reads give zero
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rdata_reg <= 8'h00;
    end else if (i_ce) begin
      if (i_rd) begin
        case (i_addr)
          CCD_DIV0_COUNTS: rdata_reg <= div0_counts_reg;
          CCD_DIV0_CTRL:   rdata_reg <= div0_ctrl_reg;
          CCD_DIV0_ROUTE:  rdata_reg <= div0_route_reg;
          CCD_DIV1_COUNTS: rdata_reg <= div1_counts_reg;
          CCD_DIV1_CTRL:   rdata_reg <= div1_ctrl_reg;
          CCD_DIV1_ROUTE:  rdata_reg <= div1_route_reg;
          CCD_SRC_SEL:     rdata_reg <= {6'h00, src_sel_reg};
          CCD_STATUS:      rdata_reg <= status_next;
          default:         rdata_reg <= 8'h00;
        endcase
      end else begin
        rdata_reg <= 8'h00;
      end
    end
  end

  assign o_rdata = rdata_reg;

  // ************************************************************
  // pin inputs
  // ************************************************************
  ccd_pin_sync u_osc_sync (
    .i_mclk  (i_mclk),
    .i_srst  (i_srst),
    .i_ce    (i_ce),
    .i_pin   (i_osc_clk),
    .o_level (osc_lvl),
    .o_rise  (osc_rise)
  );

  ccd_pin_sync u_ext_sync (
    .i_mclk  (i_mclk),
    .i_srst  (i_srst),
    .i_ce    (i_ce),
    .i_pin   (i_ext_clk),
    .o_level (ext_lvl),
    .o_rise  (ext_rise)
  );

  ccd_pin_sync u_chip_sync (
    .i_mclk  (i_mclk),
    .i_srst  (i_srst),
    .i_ce    (i_ce),
    .i_pin   (i_chip_sync),
    .o_level (sync_lvl),
    .o_rise  ()
  );

  // ************************************************************
  // divider input source
  // ************************************************************
  // both dividers share one source so a common sync release stays aligned
  logic src_is_osc;
  logic src_lvl;
  logic src_tick;

  assign src_is_osc = (src_sel_reg == CCD_SRC_OSC);
  assign src_lvl    = src_is_osc ? osc_lvl : ext_lvl;
  assign src_tick   = src_is_osc ? osc_rise : ext_rise;

  ccd_divider u_div0 (
    .i_mclk     (i_mclk),
    .i_srst     (i_srst),
    .i_ce       (i_ce),
    .i_tick     (src_tick),
    .i_src_lvl  (src_lvl),
    .i_sync     (sync_lvl),
    .i_low_cnt  (div0_counts_reg[CCD_LOW_MSB:CCD_LOW_LSB]),
    .i_high_cnt (div0_counts_reg[CCD_HIGH_MSB:CCD_HIGH_LSB]),
    .i_bypass   (div0_ctrl_reg[CCD_BYPASS_BIT]),
    .i_nosync   (div0_ctrl_reg[CCD_NOSYNC_BIT]),
    .i_force    (div0_ctrl_reg[CCD_FORCE_BIT]),
    .i_start_hi (div0_ctrl_reg[CCD_START_BIT]),
    .i_phase    (div0_ctrl_reg[CCD_PHASE_MSB:CCD_PHASE_LSB]),
    .o_div_out  (div0_out),
    .o_running  (div0_run)
  );

  ccd_divider u_div1 (
    .i_mclk     (i_mclk),
    .i_srst     (i_srst),
    .i_ce       (i_ce),
    .i_tick     (src_tick),
    .i_src_lvl  (src_lvl),
    .i_sync     (sync_lvl),
    .i_low_cnt  (div1_counts_reg[CCD_LOW_MSB:CCD_LOW_LSB]),
    .i_high_cnt (div1_counts_reg[CCD_HIGH_MSB:CCD_HIGH_LSB]),
    .i_bypass   (div1_ctrl_reg[CCD_BYPASS_BIT]),
    .i_nosync   (div1_ctrl_reg[CCD_NOSYNC_BIT]),
    .i_force    (div1_ctrl_reg[CCD_FORCE_BIT]),
    .i_start_hi (div1_ctrl_reg[CCD_START_BIT]),
    .i_phase    (div1_ctrl_reg[CCD_PHASE_MSB:CCD_PHASE_LSB]),
    .o_div_out  (div1_out),
    .o_running  (div1_run)
  );

  // ************************************************************
  // output routing
  // ************************************************************
  logic pair0_reg;
  logic pair1_reg;
  logic pair0_next;
  logic pair1_next;
  logic [1:0] dcc_reg;

  // select 01b (and the unused 11b) leave the divider on the pair
  function automatic logic route_pick(input logic direct, input logic [1:0] sel,
                                      input logic div_lvl, input logic osc,
                                      input logic ext);
    logic res;
    res = div_lvl;
    if (direct && sel == CCD_SRC_OSC) begin
      res = osc;
    end else if (direct && sel == CCD_SRC_EXT) begin
      res = ext;
    end
    return res;
  endfunction

  assign pair0_next = route_pick(div0_route_reg[CCD_DIRECT_BIT], src_sel_reg,
                                 div0_out, osc_lvl, ext_lvl);
  assign pair1_next = route_pick(div1_route_reg[CCD_DIRECT_BIT], src_sel_reg,
                                 div1_out, osc_lvl, ext_lvl);

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      pair0_reg <= 1'h0;
      pair1_reg <= 1'h0;
    end else if (i_ce) begin
      pair0_reg <= pair0_next;
      pair1_reg <= pair1_next;
    end
  end

  // correction itself is analog; this block only steers its enable
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      dcc_reg <= 2'h3;
    end else if (i_ce) begin
      dcc_reg <= {!div1_route_reg[CCD_DUTY_CORRECTION_DISABLE_BIT], !div0_route_reg[CCD_DUTY_CORRECTION_DISABLE_BIT]};
    end
  end

  assign o_pair0_output_a  = pair0_reg;
  assign o_pair0_output_b  = !pair0_reg;
  assign o_pair1_output_a  = pair1_reg;
  assign o_pair1_output_b  = !pair1_reg;
  assign o_duty_correct_en = dcc_reg;

  // ************************************************************
  // checks
  // ************************************************************
  a_reset_counts: assert property (@(posedge i_mclk)
    $past(i_srst) && !i_srst |-> div0_counts_reg == 8'h00 && div1_counts_reg == 8'hBB)
    else $error("count fields wrong after reset");

  a_reset_bypass: assert property (@(posedge i_mclk)
    $past(i_srst) && !i_srst |-> div0_ctrl_reg[7] && !div1_ctrl_reg[7])
    else $error("bypass bits wrong after reset");

  a_reset_fields: assert property (@(posedge i_mclk)
    $past(i_srst) && !i_srst |-> div0_ctrl_reg[6:0] == 7'h00 && div1_ctrl_reg == 8'h00
      && div0_route_reg == 8'h00 && div1_route_reg == 8'h00)
    else $error("control fields not clear after reset");

  a_bypass_pass: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_ce && div0_ctrl_reg[7] && !div0_route_reg[1] ##1 i_ce && div0_ctrl_reg[7]
      && !div0_route_reg[1] |=> o_pair0_output_a == $past(src_lvl, 2))
    else $error("bypassed divider does not pass source");

  a_bypass_noforce: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_ce && div1_ctrl_reg[7] && div1_ctrl_reg[5] && div1_ctrl_reg[6] && sync_lvl
      && !src_lvl |=> !div1_out)
    else $error("force acts while bypassed");

  a_direct_osc: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_ce && div0_route_reg[1] && src_sel_reg == 2'h2 |=> o_pair0_output_a == $past(osc_lvl))
    else $error("direct oscillator route wrong");

  a_direct_none: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_ce && div1_route_reg[1] && src_sel_reg == 2'h1 |=> o_pair1_output_a == $past(div1_out))
    else $error("select 01b changed routing");

  a_div_route: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_ce && !div1_route_reg[1] |=> o_pair1_output_a == $past(div1_out)
      && o_pair1_output_b != o_pair1_output_a)
    else $error("pair not driven from divider");

  a_dcc_enable: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_ce ##1 i_ce |=> o_duty_correct_en[0] == !$past(div0_route_reg[0])
      && o_duty_correct_en[1] == !$past(div1_route_reg[0]))
    else $error("duty correction enable wrong");

  c_bypass: cover property (@(posedge i_mclk) disable iff (i_srst)
    div0_ctrl_reg[7] && src_tick);
  c_direct: cover property (@(posedge i_mclk) disable iff (i_srst)
    div1_route_reg[1] && src_sel_reg == CCD_SRC_OSC);
  c_sync: cover property (@(posedge i_mclk) disable iff (i_srst)
    sync_lvl ##1 !sync_lvl ##[1:64] div1_run);

endmodule

// ===== ccd_pkg.sv
// constants and types shared by the channel clock divider block
package ccd_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam int          CCD_AW           = 10;
  localparam int          CCD_DW           = 8;
  localparam logic [9:0]  CCD_DIV0_COUNTS  = 10'h190;
  localparam logic [9:0]  CCD_DIV0_CTRL    = 10'h191;
  localparam logic [9:0]  CCD_DIV0_ROUTE   = 10'h192;
  localparam logic [9:0]  CCD_DIV1_COUNTS  = 10'h193;
  localparam logic [9:0]  CCD_DIV1_CTRL    = 10'h194;
  localparam logic [9:0]  CCD_DIV1_ROUTE   = 10'h195;
  localparam logic [9:0]  CCD_SRC_SEL      = 10'h1E1;
  localparam logic [9:0]  CCD_STATUS       = 10'h1E2;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int          CCD_LOW_MSB      = 7;
  localparam int          CCD_LOW_LSB      = 4;
  localparam int          CCD_HIGH_MSB     = 3;
  localparam int          CCD_HIGH_LSB     = 0;
  localparam int          CCD_BYPASS_BIT   = 7;
  localparam int          CCD_NOSYNC_BIT   = 6;
  localparam int          CCD_FORCE_BIT    = 5;
  localparam int          CCD_START_BIT    = 4;
  localparam int          CCD_PHASE_MSB    = 3;
  localparam int          CCD_PHASE_LSB    = 0;
  localparam int          CCD_DIRECT_BIT   = 1;
  localparam int          CCD_DUTY_CORRECTION_DISABLE_BIT   = 0;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0]  CCD_DIV0_COUNTS_RST = 8'h00;
  localparam logic [7:0]  CCD_DIV0_CTRL_RST   = 8'h80;
  localparam logic [7:0]  CCD_DIV0_ROUTE_RST  = 8'h00;
  localparam logic [7:0]  CCD_DIV1_COUNTS_RST = 8'hBB;
  localparam logic [7:0]  CCD_DIV1_CTRL_RST   = 8'h00;
  localparam logic [7:0]  CCD_DIV1_ROUTE_RST  = 8'h00;
  localparam logic [1:0]  CCD_SRC_SEL_RST     = 2'h0;

  // ************************************************************
  // source select codes
  // ************************************************************
  localparam logic [1:0]  CCD_SRC_EXT      = 2'h0;
  localparam logic [1:0]  CCD_SRC_NONE     = 2'h1;
  localparam logic [1:0]  CCD_SRC_OSC      = 2'h2;

  typedef enum logic [1:0] {
    CCD_HOLD = 2'h0,
    CCD_WAIT = 2'h1,
    CCD_RUN  = 2'h3,
    CCD_IDLE = 2'h2
  } ccd_state_t;

endpackage

// ===== ccd_pin_sync.sv
// three-flop pin synchroniser with agreement filter and rise pulse
`timescale 1ns/1ps
module ccd_pin_sync
  import ccd_pkg::*;
(
  input  wire logic i_mclk,
  input  wire logic i_srst,
  input  wire logic i_ce,
  input  wire logic i_pin,
  output logic      o_level,
  output logic      o_rise
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic lvl_reg;
  logic rise_reg;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      s1_reg <= 1'h0;
      s2_reg <= 1'h0;
      s3_reg <= 1'h0;
    end else if (i_ce) begin
      s1_reg <= i_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a change is accepted only once stages two and three agree
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      lvl_reg  <= 1'h0;
      rise_reg <= 1'h0;
    end else if (i_ce) begin
      rise_reg <= (s2_reg == s3_reg) && s3_reg && !lvl_reg;
      if (s2_reg == s3_reg) begin
        lvl_reg <= s3_reg;
      end
    end
  end

  assign o_level = lvl_reg;
  assign o_rise  = rise_reg;

endmodule

// ===== ccd_divider.sv
// one channel divider: high/low counts, phase offset, sync, force, bypass
`timescale 1ns/1ps
module ccd_divider
  import ccd_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_srst,
  input  wire logic       i_ce,
  input  wire logic       i_tick,
  input  wire logic       i_src_lvl,
  input  wire logic       i_sync,
  input  wire logic [3:0] i_low_cnt,
  input  wire logic [3:0] i_high_cnt,
  input  wire logic       i_bypass,
  input  wire logic       i_nosync,
  input  wire logic       i_force,
  input  wire logic       i_start_hi,
  input  wire logic [3:0] i_phase,
  output logic            o_div_out,
  output logic            o_running
);

  ccd_state_t state_reg;
  logic [3:0] cnt_reg;
  logic       lvl_reg;
  logic       out_reg;
  logic       sync_eff;

  assign sync_eff = i_sync && !i_nosync;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state_reg <= CCD_WAIT;
      cnt_reg   <= 4'h0;
      lvl_reg   <= 1'h0;
    end else if (i_ce) begin
      if (i_bypass) begin
        state_reg <= CCD_IDLE;
        cnt_reg   <= i_phase;
      end else if (sync_eff) begin
        state_reg <= CCD_HOLD;
        cnt_reg   <= i_phase;
        lvl_reg   <= i_start_hi;
      end else begin
        case (state_reg)
          CCD_HOLD, CCD_IDLE: begin
            state_reg <= CCD_WAIT;
            cnt_reg   <= i_phase;
            lvl_reg   <= i_start_hi;
          end
          CCD_WAIT: begin
            if (i_tick) begin
              if (cnt_reg == 4'h0) begin
                state_reg <= CCD_RUN;
                lvl_reg   <= i_start_hi;
                cnt_reg   <= i_start_hi ? i_high_cnt : i_low_cnt;
              end else begin
                cnt_reg <= cnt_reg - 4'h1;
              end
            end
          end
          CCD_RUN: begin
            if (i_tick) begin
              if (cnt_reg == 4'h0) begin
                lvl_reg <= !lvl_reg;
                cnt_reg <= lvl_reg ? i_low_cnt : i_high_cnt;
              end else begin
                cnt_reg <= cnt_reg - 4'h1;
              end
            end
          end
          default: begin
            state_reg <= CCD_WAIT;
          end
        endcase
      end
    end
  end

  // bypass passes the source through; force only counts when not bypassed
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      out_reg <= 1'h0;
    end else if (i_ce) begin
      if (i_bypass) begin
        out_reg <= i_src_lvl;
      end else if (i_sync && i_nosync) begin
        out_reg <= i_force;
      end else begin
        out_reg <= lvl_reg;
      end
    end
  end

  assign o_div_out = out_reg;
  assign o_running = (state_reg == CCD_RUN);

  // ************************************************************
  // checks
  // ************************************************************
  logic [4:0] len_reg;
  logic       full_reg;
  logic [7:0] cfg_reg;
  logic       cfg_same;

  // a count written mid-interval only applies at the next reload,
  // so the interval it lands in is not judged
  assign cfg_same = ({i_low_cnt, i_high_cnt} == cfg_reg);

  // ticks spent at the current level since the last toggle
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      len_reg  <= 5'h0;
      full_reg <= 1'h0;
      cfg_reg  <= 8'h00;
    end else if (i_ce) begin
      cfg_reg <= {i_low_cnt, i_high_cnt};
      if (state_reg != CCD_RUN || i_bypass || sync_eff || !cfg_same) begin
        len_reg  <= 5'h0;
        full_reg <= 1'h0;
      end else if (i_tick && cnt_reg == 4'h0) begin
        len_reg  <= 5'h0;
        full_reg <= 1'h1;
      end else if (i_tick) begin
        len_reg <= len_reg + 5'h1;
      end
    end
  end

  a_high_len: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_ce && full_reg && cfg_same && state_reg == CCD_RUN && !i_bypass && !sync_eff
      && i_tick && cnt_reg == 4'h0 && lvl_reg |-> len_reg == {1'h0, i_high_cnt})
    else $error("high time differs from high count plus one");

  a_low_len: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_ce && full_reg && cfg_same && state_reg == CCD_RUN && !i_bypass && !sync_eff
      && i_tick && cnt_reg == 4'h0 && !lvl_reg |-> len_reg == {1'h0, i_low_cnt})
    else $error("low time differs from low count plus one");

  a_sync_start: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_ce && sync_eff && !i_bypass ##1 i_ce && !i_bypass
      |=> out_reg == $past(i_start_hi, 2))
    else $error("synced divider not at start level");

  a_force_level: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_ce && i_sync && i_nosync && !i_bypass |=> out_reg == $past(i_force))
    else $error("forced level not shown");

  a_phase_load: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_ce && state_reg == CCD_HOLD && !sync_eff && !i_bypass
      |=> state_reg == CCD_WAIT && cnt_reg == $past(i_phase))
    else $error("phase offset not loaded on sync release");

  c_run_entry: cover property (@(posedge i_mclk) disable iff (i_srst)
    state_reg == CCD_WAIT ##1 state_reg == CCD_RUN);

endmodule

// ===== testbench.sv
// self-checking testbench for the two-channel clock divider block
`timescale 1ns/1ps
module testbench;
  import ccd_pkg::*;
  logic       i_mclk;
  logic       i_srst;
  logic       i_ce;
  logic [9:0] i_addr;
  logic [7:0] i_wdata;
  logic       i_wr;
  logic       i_rd;
  logic       i_osc_clk;
  logic       i_ext_clk;
  logic       i_chip_sync;
  logic [7:0] o_rdata;
  logic       o_pair0_output_a;
  logic       o_pair0_output_b;
  logic       o_pair1_output_a;
  logic       o_pair1_output_b;
  logic [1:0] o_duty_correct_en;
  logic [1:0] outs;
  int         errors;
  int         cmp_count;
  int         hi;
  int         lo;
  logic [7:0] d;
  logic [3:0] h;
  logic [3:0] l;
  logic [9:0] ra [7] = '{10'h190, 10'h191, 10'h192, 10'h193, 10'h194, 10'h195, 10'h1E1};
  logic [7:0] rv [7] = '{8'h00, 8'h80, 8'h00, 8'hBB, 8'h00, 8'h00, 8'h00};

  assign outs = {o_pair1_output_a, o_pair0_output_a};

  ccd_top uut (
    .i_mclk            (i_mclk),
    .i_srst            (i_srst),
    .i_ce              (i_ce),
    .i_addr            (i_addr),
    .i_wdata           (i_wdata),
    .i_wr              (i_wr),
    .i_rd              (i_rd),
    .i_osc_clk         (i_osc_clk),
    .i_ext_clk         (i_ext_clk),
    .i_chip_sync       (i_chip_sync),
    .o_rdata           (o_rdata),
    .o_pair0_output_a  (o_pair0_output_a),
    .o_pair0_output_b  (o_pair0_output_b),
    .o_pair1_output_a  (o_pair1_output_a),
    .o_pair1_output_b  (o_pair1_output_b),
    .o_duty_correct_en (o_duty_correct_en)
  );

  // ************************************************************
  // clocks: sources are exact multiples of mclk, offset so edges never coincide
  // ************************************************************
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  initial begin
    i_ext_clk = 1'b0;
    #7;
    forever #100 i_ext_clk = ~i_ext_clk;
  end
  initial begin
    i_osc_clk = 1'b0;
    #3;
    forever #150 i_osc_clk = ~i_osc_clk;
  end

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic int span(input logic [3:0] c, input int per);
    return (int'(c) + 1) * per;
  endfunction

  task automatic tick();
    @(posedge i_mclk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    @(posedge i_mclk);
    i_wr    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
    @(posedge i_mclk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd   <= 1'b0;
    #1;
    chk("rdata", {8'h00, exp}, {8'h00, o_rdata});
  endtask

  // second full high/low interval, so a config reload has landed first
  task automatic meas(input int ch, output int hi_o, output int lo_o);
    int n;
    n = 0;
    repeat (2) begin
      while (outs[ch] !== 1'b0 && n < 3000) begin tick(); n++; end
      while (outs[ch] !== 1'b1 && n < 3000) begin tick(); n++; end
      hi_o = 0;
      while (outs[ch] === 1'b1 && n < 3000) begin tick(); n++; hi_o++; end
      lo_o = 0;
      while (outs[ch] === 1'b0 && n < 3000) begin tick(); n++; lo_o++; end
    end
  endtask

  task automatic steady(input int ch, input logic exp, input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      tick();
      if (outs[ch] !== exp) bad++;
    end
    chk("steady_level", 16'h0000, bad[15:0]);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ************************************************************
  // watchdog: the whole sequence needs well under 20000 mclk cycles
  // ************************************************************
  initial begin
    #1000000;
    errors++;
    $display("ERROR watchdog expected finish seen timeout");
    print_verdict();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    errors = 0;
    cmp_count = 0;
    i_srst = 1'b1;
    i_ce = 1'b1;
    i_addr = 10'h000;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_chip_sync = 1'b0;
    void'($urandom(19387));
    repeat (16) @(posedge i_mclk);
    i_srst <= 1'b0;
    for (int i = 0; i < 7; i++) rd_chk(ra[i], rv[i]);
    chk("dcc_en", 16'h0003, {14'h0, o_duty_correct_en});
    chk("pair0_b", {15'h0, ~o_pair0_output_a}, {15'h0, o_pair0_output_b});
    chk("pair1_b", {15'h0, ~o_pair1_output_a}, {15'h0, o_pair1_output_b});
    rd_chk(10'h3FF, 8'h00);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      wr(CCD_DIV1_CTRL, d);
      rd_chk(CCD_DIV1_CTRL, d);
      wr(CCD_DIV0_ROUTE, d);
      rd_chk(CCD_DIV0_ROUTE, d & 8'h03);
      wr(CCD_DIV1_ROUTE, ~d);
      rd_chk(CCD_DIV1_ROUTE, ~d & 8'h03);
      tick();
      chk("dcc_en", {14'h0, d[0], ~d[0]}, {14'h0, o_duty_correct_en});
    end
    wr(CCD_DIV0_ROUTE, 8'h00);
    wr(CCD_DIV1_ROUTE, 8'h00);
    wr(CCD_DIV1_CTRL, 8'h00);
    meas(0, hi, lo);
    chk("bypass_hi", 16'h0004, hi[15:0]);
    chk("bypass_lo", 16'h0004, lo[15:0]);
    for (int i = 0; i < 5; i++) begin
      h = (i == 0) ? 4'h0 : 4'($urandom_range(0, 15));
      l = (i == 0) ? 4'hF : 4'($urandom_range(0, 15));
      wr(CCD_DIV1_COUNTS, {l, h});
      meas(1, hi, lo);
      chk("div1_hi", span(h, 8), hi[15:0]);
      chk("div1_lo", span(l, 8), lo[15:0]);
    end
    wr(CCD_DIV0_CTRL, 8'h00);
    wr(CCD_DIV0_COUNTS, 8'h21);
    meas(0, hi, lo);
    chk("div0_hi", 16'h0010, hi[15:0]);
    chk("div0_lo", 16'h0018, lo[15:0]);
    wr(CCD_DIV0_ROUTE, 8'h02);
    meas(0, hi, lo);
    chk("direct_ext", 16'h0004, hi[15:0]);
    wr(CCD_SRC_SEL, 8'h02);
    meas(0, hi, lo);
    chk("direct_osc", 16'h0006, hi[15:0]);
    // select 01b: a direct pair keeps its divider
    wr(CCD_DIV1_ROUTE, 8'h02);
    wr(CCD_SRC_SEL, 8'h01);
    meas(1, hi, lo);
    chk("sel01_hi", span(h, 8), hi[15:0]);
    chk("sel01_lo", span(l, 8), lo[15:0]);
    wr(CCD_SRC_SEL, 8'h00);
    wr(CCD_DIV0_ROUTE, 8'h00);
    wr(CCD_DIV1_ROUTE, 8'h00);
    // sync held: obeying divider parks at its start level
    wr(CCD_DIV1_CTRL, 8'h10);
    i_chip_sync <= 1'b1;
    repeat (20) tick();
    steady(1, 1'b1, 60);
    wr(CCD_DIV1_CTRL, 8'h60);
    repeat (10) tick();
    steady(1, 1'b1, 60);
    wr(CCD_DIV1_CTRL, 8'h40);
    repeat (10) tick();
    steady(1, 1'b0, 60);
    wr(CCD_DIV1_CTRL, 8'hE0);
    meas(1, hi, lo);
    chk("bypass_force", 16'h0004, hi[15:0]);
    // phase offset: both obey sync, release together, divider 1 lags 3 edges
    wr(CCD_DIV0_COUNTS, 8'h77);
    wr(CCD_DIV1_COUNTS, 8'h77);
    wr(CCD_DIV1_CTRL, 8'h03);
    repeat (20) tick();
    i_chip_sync <= 1'b0;
    hi = 0;
    while (outs[0] !== 1'b1 && hi < 2000) begin tick(); hi++; end
    lo = 0;
    while (outs[1] !== 1'b1 && lo < 2000) begin tick(); lo++; end
    chk("phase_skew", 16'h0018, lo[15:0]);
    // clock enable low: writes ignored, outputs frozen
    i_ce <= 1'b0;
    wr(CCD_DIV0_COUNTS, 8'h12);
    steady(0, outs[0], 40);
    i_ce <= 1'b1;
    rd_chk(CCD_DIV0_COUNTS, 8'h77);
    // second reset in mid-run restores the defaults
    i_srst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_srst <= 1'b0;
    rd_chk(CCD_DIV0_COUNTS, 8'h00);
    rd_chk(CCD_DIV1_COUNTS, 8'hBB);
    rd_chk(CCD_DIV0_CTRL, 8'h80);
    print_verdict();
  end
endmodule
